/* rtl/tdm_pair_buffer.sv */
// two-entry valid/ready buffer for outgoing channel words
`timescale 1ns/1ps
module tdm_pair_buffer #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// filling side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// draining side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	// ------------------------------------------------------------
	// handshake
	// ------------------------------------------------------------
	assign o_in_ready  = (count_q != (AW+1)'(DEPTH));
	assign o_out_valid = (count_q != '0);
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;
	assign o_out_data  = mem_q[rd_ptr_q];

	// entry storage, no reset needed since valid gates it
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= i_in_data;
	end

	// pointers and occupancy; a stalled reader lets the buffer fill
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			if (push & ~pop)
				count_q <= count_q + 1'b1;
			else if (pop & ~push)
				count_q <= count_q - 1'b1;
		end
	end

	// a stalled word stays put until taken
	property p_hold_stall;
		@(posedge i_clk) disable iff (i_rst)
		(o_out_valid && !i_out_ready) |=> (o_out_valid && $stable(o_out_data));
	endproperty
	a_hold_stall: assert property (p_hold_stall)
		else $error("buffer output changed while stalled");
endmodule

/* rtl/tdm_switch_connection_memory.sv */
// connection stores, data pages and backplane output control of a tdm switch
//
// Contract
// RQ1 - count bit periods 1..2048 from frame boundary
// RQ2 - map period to channel by stream rate
// RQ3 - select high: enable bit gates stream drive
// RQ4 - select high: both drive-control lines high impedance
// RQ5 - store received channel at stream/channel location
// RQ6 - four data pages written in rotation
// RQ7 - read data three frames after writing
// RQ8 - local store: 4096 words, bit 15 source
// RQ9 - backplane store: 4096 words, bit 15 source
// RQ10 - bits 14:13 mode; connection mode source
// RQ11 - message mode sends low byte
// RQ12 - software keeps stream/channel numbers legal
// RQ13 - select 000 local, 001 backplane store
// RQ14 - mode bit first, then go bit
// RQ15 - block fill writes pattern into bits 15:13
// RQ16 - go clears itself within 125 us
// RQ17 - clearing go or mode aborts fill
// RQ18 - zero pattern: hi-z/high, stream 0 channel 0
// RQ19 - select low: control line copies enable bit
// RQ20 - control lines repeat bit per rate
// RQ21 - even streams first line, odd second
// RQ22 - bit 13 is per-channel output enable
`timescale 1ns/1ps
`include "tdm_switch_map.svh"
module tdm_switch_connection_memory #(
	parameter int BP_LIMIT_CYCLES = `BP_LIMIT_CYCLES_CALC
) (
	// clock and reset
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	// link timing pins
	input  wire logic                 i_output_bit_clock,
	input  wire logic                 i_frame_sync,
	// backplane configuration
	input  wire logic                 i_backplane_drive_select,
	input  wire logic [31:0]          i_backplane_rate,
	// block programming control
	input  wire logic                 i_block_program_mode,
	input  wire logic                 i_block_program_go_set,
	input  wire logic                 i_block_program_go_clear,
	input  wire logic [2:0]           i_local_block_pattern,
	input  wire logic [2:0]           i_backplane_block_pattern,
	output logic                      o_block_program_go,
	// host store access
	input  wire logic [2:0]           i_mem_select,
	input  wire logic [11:0]          i_host_addr,
	input  wire tdm_switch_pkg::cm_word_t i_host_wdata,
	input  wire logic                 i_host_wr,
	input  wire logic                 i_host_rd,
	output tdm_switch_pkg::cm_word_t  o_host_rdata,
	output logic                      o_host_rdata_valid,
	// received channel bytes
	input  wire logic                 i_rx_valid,
	input  wire logic                 i_rx_local,
	input  wire logic [3:0]           i_rx_stream,
	input  wire logic [7:0]           i_rx_channel,
	input  wire logic [7:0]           i_rx_byte,
	// output channel requests and answers
	input  wire logic                 i_tx_req_valid,
	input  wire logic                 i_tx_req_local,
	input  wire logic [3:0]           i_tx_req_stream,
	input  wire logic [7:0]           i_tx_req_channel,
	output logic                      o_tx_req_ready,
	output logic                      o_tx_valid,
	input  wire logic                 i_tx_ready,
	output logic [7:0]                o_tx_byte,
	output logic                      o_tx_enable,
	// backplane output pins
	output logic [15:0]               o_backplane_serial_oe_n,
	output logic                      o_backplane_ext_drive_ctrl_even,
	output logic                      o_backplane_ext_drive_ctrl_even_oe_n,
	output logic                      o_backplane_ext_drive_ctrl_odd,
	output logic                      o_backplane_ext_drive_ctrl_odd_oe_n,
	// frame status
	output logic [11:0]               o_period,
	output logic [1:0]                o_write_page
);
	import tdm_switch_pkg::*;

	// ------------------------------------------------------------
	// storage and state
	// ------------------------------------------------------------
	cm_word_t    local_connection_store     [`CM_DEPTH];
	cm_word_t    backplane_connection_store [`CM_DEPTH];
	logic [7:0]  data_mem [2][`DM_PAGES][`CM_DEPTH];
	logic        bclk_meta_q, bclk_s_q, bclk_prev_q;
	logic        fsync_meta_q, fsync_s_q, fsync_prev_q;
	logic        dsel_meta_q, dsel_s_q;
	logic        bit_edge, frame_edge, frame_pending_q;
	logic [11:0] period_q;
	logic [1:0]  wr_page_q;
	logic [1:0]  rd_page;
	bp_state_e   bp_state_q;
	logic [11:0] bp_addr_q;
	logic        bp_abort, bp_write, bp_last;
	logic [15:0] bp_cycles_q;
	logic [11:0] ctrl_pos;
	logic [11:0] data_pos;
	logic [11:0] even_addr, odd_addr;
	logic [15:0] lane_oe_n;
	cm_word_t    tx_word;
	logic        tx_src_local;
	logic [7:0]  tx_byte;
	logic        tx_push;

	// channel index inside a frame position for a given stream rate
	function automatic logic [7:0] chan_of(input logic [10:0] pos, input logic [1:0] rate);
		logic [7:0] ch;
		ch = 8'h00;
		case (rate_e'(rate))
			RATE_16M: ch = pos[10:3];
			RATE_8M:  ch = {1'b0, pos[10:4]};
			RATE_4M:  ch = {2'b00, pos[10:5]};
			RATE_2M:  ch = {3'b000, pos[10:6]};
			default:  ch = 8'h00;
		endcase
		return ch;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------------------
	// two flops per pin; edge logic compares the second stage with a third delay flop
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			bclk_meta_q  <= 1'b0;
			bclk_s_q     <= 1'b0;
			bclk_prev_q  <= 1'b0;
			fsync_meta_q <= 1'b0;
			fsync_s_q    <= 1'b0;
			fsync_prev_q <= 1'b0;
			dsel_meta_q  <= 1'b0;
			dsel_s_q     <= 1'b0;
		end
		else
		begin
			bclk_meta_q  <= i_output_bit_clock;
			bclk_s_q     <= bclk_meta_q;
			bclk_prev_q  <= bclk_s_q;
			fsync_meta_q <= i_frame_sync;
			fsync_s_q    <= fsync_meta_q;
			fsync_prev_q <= fsync_s_q;
			dsel_meta_q  <= i_backplane_drive_select;
			dsel_s_q     <= dsel_meta_q;
		end
	end

	assign bit_edge   = bclk_s_q & ~bclk_prev_q;
	assign frame_edge = fsync_s_q & ~fsync_prev_q;

	// ------------------------------------------------------------
	// period counter and page rotation
	// ------------------------------------------------------------
	// a frame mark is held until the next bit edge; a new mark wins over the clear
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			frame_pending_q <= 1'b0;
		else if (frame_edge)
			frame_pending_q <= 1'b1;
		else if (bit_edge)
			frame_pending_q <= 1'b0;
	end

	// periods run 1..2048, the page advances at each frame start
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			period_q  <= `PERIOD_RESET;
			wr_page_q <= `PAGE_RESET;
		end
		else if (bit_edge)
		begin
			if (frame_pending_q || period_q == `PERIODS_PER_FRAME) // RQ1
			begin
				period_q  <= 12'd1;
				wr_page_q <= wr_page_q + 2'h1; // RQ6
			end
			else
				period_q <= period_q + 12'd1;
		end
	end

	// the page written three frames ago is the one read now
	assign rd_page      = wr_page_q - `DM_READ_LAG; // RQ7
	assign o_period     = period_q;
	assign o_write_page = wr_page_q;

	// ------------------------------------------------------------
	// data memory write
	// ------------------------------------------------------------
	// each deserialised channel lands at its stream/channel slot of the live page
	always_ff @(posedge i_core_clk)
	begin
		if (i_rx_valid)
			data_mem[i_rx_local][wr_page_q][{i_rx_stream, i_rx_channel}] <= i_rx_byte; // RQ5
	end

	// ------------------------------------------------------------
	// block programming sequencer
	// ------------------------------------------------------------
	assign bp_abort = ~i_block_program_mode | i_block_program_go_clear; // RQ17
	assign bp_write = (bp_state_q == BP_RUN) & ~bp_abort;
	assign bp_last  = bp_addr_q == `CM_LAST_ADDR;

	// one word per cycle, so both stores fill in 4096 cycles, well inside the limit
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			bp_state_q         <= BP_IDLE;
			bp_addr_q          <= 12'h000;
			o_block_program_go <= 1'b0;
		end
		else
		begin
			case (bp_state_q)
				BP_IDLE:
				begin
					if (i_block_program_go_set && i_block_program_mode) // RQ14
					begin
						bp_state_q         <= BP_RUN;
						bp_addr_q          <= 12'h000;
						o_block_program_go <= 1'b1;
					end
				end
				BP_RUN:
				begin
					if (bp_abort || bp_last) // RQ16 RQ17
					begin
						bp_state_q         <= BP_IDLE;
						o_block_program_go <= 1'b0;
					end
					else
						bp_addr_q <= bp_addr_q + 12'h001;
				end
				default:
				begin
					bp_state_q         <= BP_IDLE;
					o_block_program_go <= 1'b0;
				end
			endcase
		end
	end

	// cycles spent in one fill, watched against the completion limit
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || bp_state_q != BP_RUN)
			bp_cycles_q <= 16'h0000;
		else
			bp_cycles_q <= bp_cycles_q + 16'h0001;
	end

	// ------------------------------------------------------------
	// connection stores
	// ------------------------------------------------------------
	// a fill owns both stores; host writes are dropped while it runs
	always_ff @(posedge i_core_clk)
	begin
		if (bp_write)
		begin
			local_connection_store[bp_addr_q] <=
				{i_local_block_pattern, `CM_PAT_LSB'(0)}; // RQ15 RQ18 RQ8
			backplane_connection_store[bp_addr_q] <=
				{i_backplane_block_pattern, `CM_PAT_LSB'(0)}; // RQ15 RQ18 RQ9
		end
		else if (i_host_wr && bp_state_q == BP_IDLE)
		begin
			if (i_mem_select == `SEL_LOCAL_STORE) // RQ13
				local_connection_store[i_host_addr] <= i_host_wdata;
			else if (i_mem_select == `SEL_BACKPLANE_STORE)
				backplane_connection_store[i_host_addr] <= i_host_wdata;
		end
	end

	// host read answers one cycle later; unknown selects read zero
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_host_rdata       <= `CM_RESET_WORD;
			o_host_rdata_valid <= 1'b0;
		end
		else
		begin
			o_host_rdata_valid <= i_host_rd;
			if (i_host_rd)
			begin
				if (i_mem_select == `SEL_LOCAL_STORE)
					o_host_rdata <= local_connection_store[i_host_addr];
				else if (i_mem_select == `SEL_BACKPLANE_STORE)
					o_host_rdata <= backplane_connection_store[i_host_addr];
				else
					o_host_rdata <= `CM_RESET_WORD;
			end
		end
	end

	// ------------------------------------------------------------
	// switched output words
	// ------------------------------------------------------------
	// bit 15 meaning flips between stores: zero picks the opposite port
	assign tx_word      = i_tx_req_local ? local_connection_store[{i_tx_req_stream, i_tx_req_channel}]
	                                     : backplane_connection_store[{i_tx_req_stream, i_tx_req_channel}];
	assign tx_src_local = i_tx_req_local ? tx_word[`CM_SRC_BIT] : ~tx_word[`CM_SRC_BIT]; // RQ8 RQ9
	assign tx_byte      = tx_word[`CM_MSG_BIT] ? tx_word[7:0] // RQ11
	                                           : data_mem[tx_src_local][rd_page][tx_word[11:0]]; // RQ10
	assign tx_push      = i_tx_req_valid & o_tx_req_ready;

	// the pair buffer absorbs a receiver stall without dropping a word
	tdm_pair_buffer #(
		.WIDTH (9),
		.DEPTH (2)
	) u_tx_buffer (
		.i_clk       (i_core_clk),
		.i_rst       (i_rst),
		.i_in_valid  (i_tx_req_valid),
		.o_in_ready  (o_tx_req_ready),
		.i_in_data   ({tx_word[`CM_OE_BIT], tx_byte}), // RQ22
		.o_out_valid (o_tx_valid),
		.i_out_ready (i_tx_ready),
		.o_out_data  ({o_tx_enable, o_tx_byte})
	);

	// ------------------------------------------------------------
	// backplane per-channel drive control
	// ------------------------------------------------------------
	// control slots lead the frame: period 2039 is position zero
	assign ctrl_pos  = period_q + `CTRL_OFFSET; // RQ1
	assign data_pos  = period_q - 12'd1;
	// each slot of eight carries one even and one odd stream
	assign even_addr = {ctrl_pos[2:0], 1'b0,
		chan_of(ctrl_pos[10:0], i_backplane_rate[{ctrl_pos[2:0], 2'b00} +: 2])}; // RQ21 RQ2
	assign odd_addr  = {ctrl_pos[2:0], 1'b1,
		chan_of(ctrl_pos[10:0], i_backplane_rate[{ctrl_pos[2:0], 2'b10} +: 2])}; // RQ21 RQ20

	// per-stream direct high impedance from the enable bit of the live channel while select is high; select low drives every stream
	for (genvar s = 0; s < 16; s++)
	begin : g_lane
		logic [7:0] lane_chan;
		assign lane_chan    = chan_of(data_pos[10:0], i_backplane_rate[2*s +: 2]); // RQ2
		assign lane_oe_n[s] = dsel_s_q &
			~backplane_connection_store[{4'(s), lane_chan}][`CM_OE_BIT]; // RQ3 RQ22
	end

	// pin outputs are registered so they never glitch mid period
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_backplane_serial_oe_n              <= 16'hffff;
			o_backplane_ext_drive_ctrl_even      <= 1'b0;
			o_backplane_ext_drive_ctrl_odd       <= 1'b0;
			o_backplane_ext_drive_ctrl_even_oe_n <= 1'b1;
			o_backplane_ext_drive_ctrl_odd_oe_n  <= 1'b1;
		end
		else
		begin
			o_backplane_serial_oe_n              <= lane_oe_n;
			o_backplane_ext_drive_ctrl_even      <= backplane_connection_store[even_addr][`CM_OE_BIT]; // RQ19
			o_backplane_ext_drive_ctrl_odd       <= backplane_connection_store[odd_addr][`CM_OE_BIT]; // RQ19
			o_backplane_ext_drive_ctrl_even_oe_n <= dsel_s_q; // RQ4
			o_backplane_ext_drive_ctrl_odd_oe_n  <= dsel_s_q; // RQ4
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_bp_start;
		(bp_state_q == BP_IDLE) && i_block_program_go_set && i_block_program_mode;
	endsequence
	sequence s_bp_running;
		o_block_program_go && (bp_state_q == BP_RUN);
	endsequence

	property p_period_range;
		@(posedge i_core_clk) disable iff (i_rst)
		(period_q >= 12'd1) && (period_q <= `PERIODS_PER_FRAME);
	endproperty
	a_period_range: assert property (p_period_range) // RQ1
		else $error("period count left 1..2048");

	property p_page_turn;
		@(posedge i_core_clk) disable iff (i_rst)
		(bit_edge && period_q == `PERIODS_PER_FRAME)
			|=> (period_q == 12'd1) && (wr_page_q == $past(wr_page_q) + 2'h1);
	endproperty
	a_page_turn: assert property (p_page_turn) // RQ6
		else $error("page did not rotate at frame wrap");

	property p_read_lag;
		@(posedge i_core_clk) disable iff (i_rst)
		(bit_edge && period_q == `PERIODS_PER_FRAME) |=> (rd_page == $past(wr_page_q) - 2'h2);
	endproperty
	a_read_lag: assert property (p_read_lag) // RQ7
		else $error("read page not three frames behind");

	property p_bp_start;
		@(posedge i_core_clk) disable iff (i_rst)
		s_bp_start |=> s_bp_running ##1 (bp_addr_q == 12'h001 || !o_block_program_go);
	endproperty
	a_bp_start: assert property (p_bp_start) // RQ14
		else $error("fill did not start on go with mode set");

	property p_bp_word;
		@(posedge i_core_clk) disable iff (i_rst)
		bp_write |=> (local_connection_store[$past(bp_addr_q)] ==
			{$past(i_local_block_pattern), 13'h0000})
			&& (backplane_connection_store[$past(bp_addr_q)] ==
			{$past(i_backplane_block_pattern), 13'h0000});
	endproperty
	a_bp_word: assert property (p_bp_word) // RQ15
		else $error("fill word does not match pattern");

	property p_bp_limit;
		@(posedge i_core_clk) disable iff (i_rst)
		s_bp_running |-> (bp_cycles_q < 16'(BP_LIMIT_CYCLES)) && (bp_cycles_q <= 16'd4096);
	endproperty
	a_bp_limit: assert property (p_bp_limit) // RQ16
		else $error("fill ran past its time limit");

	property p_bp_abort;
		@(posedge i_core_clk) disable iff (i_rst)
		(s_bp_running ##0 bp_abort) |=> !o_block_program_go && (bp_state_q == BP_IDLE);
	endproperty
	a_bp_abort: assert property (p_bp_abort) // RQ17
		else $error("fill not aborted");

	property p_ctrl_hiz;
		@(posedge i_core_clk) disable iff (i_rst)
		dsel_s_q |=> o_backplane_ext_drive_ctrl_even_oe_n && o_backplane_ext_drive_ctrl_odd_oe_n;
	endproperty
	a_ctrl_hiz: assert property (p_ctrl_hiz) // RQ4
		else $error("drive-control lines driven while select high");

	property p_ctrl_copy;
		@(posedge i_core_clk) disable iff (i_rst)
		(!dsel_s_q && bp_state_q == BP_IDLE && !i_host_wr)
			|=> o_backplane_ext_drive_ctrl_even ==
				$past(backplane_connection_store[even_addr][`CM_OE_BIT]);
	endproperty
	a_ctrl_copy: assert property (p_ctrl_copy) // RQ19
		else $error("even control line does not copy enable bit");

	property p_lane_hiz;
		@(posedge i_core_clk) disable iff (i_rst)
		(dsel_s_q && !lane_oe_n[0]) |=> !o_backplane_serial_oe_n[0];
	endproperty
	a_lane_hiz: assert property (p_lane_hiz) // RQ3
		else $error("stream 0 drive does not follow enable bit");

	property p_msg_byte;
		@(posedge i_core_clk) disable iff (i_rst)
		(tx_push && tx_word[`CM_MSG_BIT] && !o_tx_valid) |=> o_tx_valid && (o_tx_byte == $past(tx_word[7:0]));
	endproperty
	a_msg_byte: assert property (p_msg_byte) // RQ11
		else $error("message byte not sent");
endmodule

/* rtl/tdm_switch_map.svh */
// timing counts, field positions and reset values of the switch connection logic
`ifndef TDM_SWITCH_MAP_SVH
`define TDM_SWITCH_MAP_SVH

// ------------------------------------------------------------
// frame timing
// ------------------------------------------------------------
`define PERIODS_PER_FRAME 12'd2048
`define CTRL_FIRST_PERIOD 12'd2039
`define CTRL_OFFSET       (`PERIODS_PER_FRAME - `CTRL_FIRST_PERIOD)
`define PERIOD_RESET      12'd2048
`define CLK_PERIOD_NS     10
`define BP_LIMIT_US       125
`define BP_LIMIT_CYCLES_CALC ((`BP_LIMIT_US * 1000) / `CLK_PERIOD_NS)

// ------------------------------------------------------------
// connection word layout
// ------------------------------------------------------------
`define CM_DEPTH      4096
`define CM_LAST_ADDR  12'hfff
`define CM_SRC_BIT    15
`define CM_MSG_BIT    14
`define CM_OE_BIT     13
`define CM_PAT_LSB    13
`define CM_RESET_WORD 16'h0000

// ------------------------------------------------------------
// host memory select codes and data memory pages
// ------------------------------------------------------------
`define SEL_LOCAL_STORE     3'h0
`define SEL_BACKPLANE_STORE 3'h1
`define DM_PAGES            4
`define DM_READ_LAG         2'h3
`define PAGE_RESET          2'h0

`endif

/* rtl/tdm_switch_pkg.sv */
// types shared by the switch connection logic
package tdm_switch_pkg;
	// stream rate code per output stream
	typedef enum logic [1:0] {
		RATE_2M  = 2'h0,
		RATE_4M  = 2'h1,
		RATE_8M  = 2'h2,
		RATE_16M = 2'h3
	} rate_e;

	// block programming sequencer, one-hot
	typedef enum logic [1:0] {
		BP_IDLE = 2'b01,
		BP_RUN  = 2'b10
	} bp_state_e;

	typedef logic [15:0] cm_word_t;
endpackage

/* verif/tdm_backplane_model.sv */
// backplane side model: output bit clock and frame marks
`timescale 1ns/1ps
module tdm_backplane_model (
	// frame length select
	input  wire logic i_short,
	// link timing pins
	output logic      o_bit_clk,
	output logic      o_frame_sync
);
	logic [3:0] cnt_q = 4'h0;
	// --------------------------------
	// bit clock runs free at 125 ns
	// --------------------------------
	initial
	begin
		o_bit_clk = 1'b0;
		forever #62.5 o_bit_clk = ~o_bit_clk;
	end
	// 16-period frames keep page rotation short; marks change off the counted edge
	always @(negedge o_bit_clk)
	begin
		cnt_q <= cnt_q + 4'h1;
		o_frame_sync <= i_short && cnt_q == 4'hf;
	end
endmodule

/* verif/tdm_switch_connection_memory_tb.sv */
// self-checking bench of the switch connection logic
`timescale 1ns/1ps
module tdm_switch_connection_memory_tb;
	import tdm_switch_pkg::*;
	logic        clk, rst, bclk, fsync, sel, mode, gset, gclr, wr, rd, rxv, rxl;
	logic        txv, txl, txrdy, short, rvalid, go, treq_rdy, tvalid, ten;
	logic        ev, even_oe_n, od, odd_oe_n;
	logic [2:0]  msel, lpat, bpat;
	logic [3:0]  rxs, txs;
	logic [7:0]  rxc, rxb, txc, tbyte;
	logic [11:0] addr, period;
	logic [15:0] ser_oe_n;
	logic [31:0] rate;
	logic [1:0]  wpage, p;
	cm_word_t    wdata, rdata;
	int          num_errors, checks, n;
	tdm_backplane_model far (.i_short(short), .o_bit_clk(bclk), .o_frame_sync(fsync));
	tdm_switch_connection_memory uut (.i_core_clk(clk), .i_rst(rst),
		.i_output_bit_clock(bclk), .i_frame_sync(fsync), .i_backplane_drive_select(sel),
		.i_backplane_rate(rate), .i_block_program_mode(mode),
		.i_block_program_go_set(gset), .i_block_program_go_clear(gclr),
		.i_local_block_pattern(lpat), .i_backplane_block_pattern(bpat),
		.o_block_program_go(go), .i_mem_select(msel), .i_host_addr(addr),
		.i_host_wdata(wdata), .i_host_wr(wr), .i_host_rd(rd), .o_host_rdata(rdata),
		.o_host_rdata_valid(rvalid), .i_rx_valid(rxv), .i_rx_local(rxl), .i_rx_stream(rxs),
		.i_rx_channel(rxc), .i_rx_byte(rxb), .i_tx_req_valid(txv), .i_tx_req_local(txl),
		.i_tx_req_stream(txs), .i_tx_req_channel(txc), .o_tx_req_ready(treq_rdy),
		.o_tx_valid(tvalid), .i_tx_ready(txrdy), .o_tx_byte(tbyte), .o_tx_enable(ten),
		.o_backplane_serial_oe_n(ser_oe_n), .o_backplane_ext_drive_ctrl_even(ev),
		.o_backplane_ext_drive_ctrl_even_oe_n(even_oe_n),
		.o_backplane_ext_drive_ctrl_odd(od), .o_backplane_ext_drive_ctrl_odd_oe_n(odd_oe_n),
		.o_period(period), .o_write_page(wpage));
	// ------------------------------
	// clock, compare and access tasks
	// ------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// bounded wait on the period count; a long frame takes about 25600 cycles
	task automatic wait_period(input logic [11:0] v);
		n = 0;
		while (period !== v && n < 30000)
		begin
			cyc(1);
			n++;
		end
		chk(16'(n < 30000), 16'h1);
		cyc(1);
	endtask
	task automatic hwr(input logic [2:0] s, input logic [11:0] a, input cm_word_t d);
		@(negedge clk);
		msel = s;
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
	endtask
	task automatic hrd(input logic [2:0] s, input logic [11:0] a, input cm_word_t e);
		@(negedge clk);
		msel = s;
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		n = 0;
		while (rvalid !== 1'b1 && n < 4)
		begin
			cyc(1);
			n++;
		end
		chk(16'(rvalid), 16'h1);
		chk(rdata, e);
	endtask
	task automatic treq(input logic [7:0] c);
		@(negedge clk);
		txl = 1'b1;
		txs = 4'h0;
		txc = c;
		txv = 1'b1;
		while (treq_rdy !== 1'b1)
			cyc(1);
		cyc(1);
		txv = 1'b0;
	endtask
	task automatic tpop(input logic [7:0] b, input logic e);
		// one idle edge first so a back-to-back call never re-raises ready in the same step
		cyc(1);
		n = 0;
		while (tvalid !== 1'b1 && n < 8)
		begin
			cyc(1);
			n++;
		end
		chk(16'(tvalid), 16'h1);
		chk(16'({ten, tbyte}), 16'({e, b}));
		txrdy = 1'b1;
		cyc(1);
		txrdy = 1'b0;
	endtask
	task automatic pulse_go;
		@(negedge clk);
		gset = 1'b1;
		cyc(1);
		gset = 1'b0;
	endtask
	// ------------------------------
	// test sequence
	// ------------------------------
	initial
	begin
		{rst, sel, mode, gset, gclr, wr, rd, rxv, rxl, txv, txl, txrdy, short} = 13'h1000;
		{msel, lpat, bpat, addr, wdata, rxs, rxc, rxb, txs, txc} = '0;
		// stream 2 at the lowest rate so its control bit repeats; all others at the highest
		rate = 32'hffff_ffcf;
		num_errors = 0;
		checks = 0;
		cyc(20);
		chk(ser_oe_n, 16'hffff);
		rst = 1'b0;
		cyc(1);
		chk(16'({go, tvalid, treq_rdy, period}), 16'h1800);
		chk(ser_oe_n, 16'h0000);
		hwr(3'h1, 12'h000, 16'h2000);
		hwr(3'h1, 12'h100, 16'h0000);
		hwr(3'h1, 12'h001, 16'h0000);
		hwr(3'h1, 12'h200, 16'h2000);
		hwr(3'h1, 12'h201, 16'h0000);
		hrd(3'h1, 12'h000, 16'h2000);
		hrd(3'h2, 12'h000, 16'h0000);
		wait_period(12'd2039);
		chk(16'({ev, od, even_oe_n, odd_oe_n}), 16'h8);
		wait_period(12'd2047);
		chk(16'(ev), 16'h0);
		wait_period(12'd2048);
		chk(16'(ev), 16'h1);
		sel = 1'b1;
		wait_period(12'd1);
		chk(16'({ser_oe_n[0], even_oe_n, odd_oe_n}), 16'h3);
		// short frames from here on so that pages rotate quickly
		short = 1'b1;
		hwr(3'h0, 12'h005, 16'ha102);
		hwr(3'h0, 12'h006, 16'h40c3);
		hrd(3'h0, 12'h005, 16'ha102);
		@(negedge clk);
		{rxv, rxl, rxs, rxc, rxb} = {2'b11, 4'h1, 8'h02, 8'h5a};
		p = wpage;
		cyc(1);
		rxv = 1'b0;
		n = 0;
		while (wpage !== p + 2'h3 && n < 2000)
		begin
			cyc(1);
			n++;
		end
		chk(16'(wpage === p + 2'h3), 16'h1);
		treq(8'h05);
		treq(8'h06);
		chk(16'(treq_rdy), 16'h0);
		tpop(8'h5a, 1'b1);
		tpop(8'hc3, 1'b0);
		pulse_go();
		cyc(1);
		chk(16'(go), 16'h0);
		mode = 1'b1;
		lpat = 3'h5;
		bpat = 3'h3;
		pulse_go();
		cyc(5);
		gclr = 1'b1;
		cyc(2);
		chk(16'(go), 16'h0);
		gclr = 1'b0;
		pulse_go();
		n = 0;
		while (go === 1'b1 && n < 13000)
		begin
			cyc(1);
			n++;
		end
		chk(16'(n >= 4096 && n < 12500), 16'h1);
		hrd(3'h0, 12'h000, 16'ha000);
		hrd(3'h0, 12'hfff, 16'ha000);
		hrd(3'h1, 12'hfff, 16'h6000);
		conclude();
	end
	// cuts a hang short well past the expected run length
	initial
	begin
		#900000;
		num_errors++;
		conclude();
	end
endmodule
